/* rtl/ssl_consts.vh */
// constants for the serial shift latch with tri-state outputs
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH

// stage count of the shift chain and width of the holding latch
`define SSL_STAGES        8
// field positions inside the chain, first and last stage
`define SSL_FIRST_BIT     0
`define SSL_LAST_BIT      7
// stage whose value reaches the last stage and the cascade output
`define SSL_SEVENTH_BIT   6
// depth of the capture fifo
`define SSL_FIFO_DEPTH    32
// width of the shift counter and its saturation value
`define SSL_CNT_W         4
`define SSL_CNT_MAX       4'hf
// reset values
`define SSL_CHAIN_RST     8'h00
`define SSL_LATCH_RST     8'h00
`define SSL_CNT_RST       4'h0
// clock period of clk_sys in ns
`define SSL_CLK_PERIOD_NS 10
// pin synchroniser depth, in clk_sys cycles
`define SSL_SYNC_CYCLES   2

`endif

/* rtl/ssl_fifo.v */
// synchronous fifo with valid and ready on both sides
`default_nettype none

module ssl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_sys,   // system clock
  input  wire             rstn,      // sync reset, active low
  input  wire [WIDTH-1:0] in_data,   // word to store
  input  wire             in_valid,  // word offered
  output reg              in_ready,  // room for a word
  output wire [WIDTH-1:0] out_data,  // oldest word
  output reg              out_valid, // a word is held
  input  wire             out_ready  // drain side takes it
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // occupancy; flags are registered so ports come straight from flops
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      count     <= {(AW+1){1'b0}};
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= (next_count != DEPTH[AW:0]);
      out_valid <= (next_count != {(AW+1){1'b0}});
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : rd_ptr + 1'b1;
      end
    end
  end

  // storage has no reset; only words behind the pointers are read
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

/* rtl/ssl_top.v */
// serial shift chain, holding latch, tri-state parallel outputs
//
// Function
// - every shift clock rising edge advances the 8-stage chain one stage
// - rising edge puts old seventh stage into eighth stage and cascade out
// - falling cascade output copies rising cascade on next falling edge
// - rising cascade output can feed the serial input of another chain
// - each stage feeds one latch bit, captured on strobe falling edge
// - strobe high makes latch follow chain; strobe low holds outputs
// - outputs driven only while enable high; shifting continues regardless
`include "ssl_consts.vh"
`default_nettype none

module ssl_top #(
  parameter STAGES     = `SSL_STAGES,
  parameter FIFO_DEPTH = `SSL_FIFO_DEPTH,
  parameter FIFO_AW    = 5
) (
  input  wire              clk_sys,           // 100 MHz system clock
  input  wire              rstn,              // sync reset, active low
  input  wire              ser_data_pin,      // serial data from host
  input  wire              shift_clk_pin,     // shift clock from host
  input  wire              strobe_pin,        // latch strobe from host
  input  wire              out_en_pin,        // output enable, high drives
  output reg  [STAGES-1:0] parallel_out,      // latch value to pins
  output reg  [STAGES-1:0] parallel_out_oe_n, // low while pins driven
  output reg               cascade_rise_out,  // last stage, rising edge
  output reg               cascade_fall_out,  // last stage, falling edge
  output wire [STAGES-1:0] cap_data,          // captured latch word
  output wire              cap_valid,         // captured word waiting
  input  wire              cap_ready,         // user takes the word
  output wire              cap_room,          // fifo accepts a capture
  output reg               cap_overflow,      // pulse: capture dropped
  output reg  [`SSL_CNT_W-1:0] shift_count    // shifts since last capture
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first flop only feeds the second
  reg              data_m;
  reg              data_s;
  reg              sclk_m;
  reg              sclk_s;
  reg              sclk_d;
  reg              strb_m;
  reg              strb_s;
  reg              strb_d;
  reg              oe_m;
  reg              oe_s;

  // chain, latch and derived strobes
  reg [STAGES-1:0] chain;
  reg [STAGES-1:0] next_chain;
  reg [STAGES-1:0] latch_q;
  reg [STAGES-1:0] next_latch;
  wire             sclk_rise;
  wire             sclk_fall;
  wire             strb_fall;
  wire             fifo_in_ready;
  reg              cap_push;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      data_m <= 1'b0;
      data_s <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      strb_m <= 1'b0;
      strb_s <= 1'b0;
      strb_d <= 1'b0;
      oe_m   <= 1'b0;
      oe_s   <= 1'b0;
    end else begin
      data_m <= ser_data_pin;
      data_s <= data_m;
      sclk_m <= shift_clk_pin;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      strb_m <= strobe_pin;
      strb_s <= strb_m;
      strb_d <= strb_s;
      oe_m   <= out_en_pin;
      oe_s   <= oe_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detection on the synchronised copies only
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign strb_fall = ~strb_s & strb_d;

  // shift function: new bit enters stage one, the rest move up
  function [STAGES-1:0] ssl_shift;
    input [STAGES-1:0] cur;
    input              din;
    begin
      ssl_shift = {cur[STAGES-2:0], din};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next chain value; data is sampled with the same sync delay as clock
  always @* begin
    next_chain = chain;
    if (sclk_rise) begin
      next_chain = ssl_shift(chain, data_s);
    end
  end

  // chain and rising cascade; enable never gates the shift
  always @(posedge clk_sys) begin
    if (!rstn) begin
      chain            <= `SSL_CHAIN_RST;
      cascade_rise_out <= 1'b0;
    end else begin
      chain <= next_chain;
      if (sclk_rise) begin
        // old seventh stage lands in the last stage and cascade pin
        cascade_rise_out <= chain[STAGES-2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // falling cascade: retimed half a shift clock later for slow receivers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cascade_fall_out <= 1'b0;
    end else if (sclk_fall) begin
      cascade_fall_out <= cascade_rise_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch: follows chain while strobe high, so it sees this cycle's shift
  always @* begin
    next_latch = latch_q;
    if (strb_s) begin
      next_latch = next_chain;
    end
  end

  // strobe fall stops following: the last followed value is the capture
  always @(posedge clk_sys) begin
    if (!rstn) begin
      latch_q <= `SSL_LATCH_RST;
    end else begin
      latch_q <= next_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers: value and enable both registered from latch and oe
  always @(posedge clk_sys) begin
    if (!rstn) begin
      parallel_out      <= `SSL_LATCH_RST;
      parallel_out_oe_n <= {STAGES{1'b1}};
    end else begin
      // bit 0 is parallel_out_first, top bit is parallel_out_last
      parallel_out      <= next_latch;
      parallel_out_oe_n <= {STAGES{~oe_s}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture path: each strobe fall offers the held word to the fifo;
  // the pins cannot be stalled, so a full fifo drops and flags it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cap_push     <= 1'b0;
      cap_overflow <= 1'b0;
    end else begin
      cap_push     <= strb_fall & fifo_in_ready;
      cap_overflow <= strb_fall & ~fifo_in_ready;
    end
  end

  // registered copy of the captured word, aligned with cap_push
  reg [STAGES-1:0] cap_word;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cap_word <= `SSL_LATCH_RST;
    end else if (strb_fall) begin
      cap_word <= latch_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shifts since the last capture, saturating; host sanity aid
  always @(posedge clk_sys) begin
    if (!rstn) begin
      shift_count <= `SSL_CNT_RST;
    end else if (strb_fall) begin
      shift_count <= sclk_rise ? 4'h1 : `SSL_CNT_RST;
    end else if (sclk_rise && shift_count != `SSL_CNT_MAX) begin
      shift_count <= shift_count + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture fifo; its ready reaches the user as cap_room
  ssl_fifo #(
    .WIDTH (STAGES),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_data   (cap_word),
    .in_valid  (cap_push),
    .in_ready  (fifo_in_ready),
    .out_data  (cap_data),
    .out_valid (cap_valid),
    .out_ready (cap_ready)
  );

  assign cap_room = fifo_in_ready;

endmodule

`default_nettype wire

/* tb/ssl_host_model.sv */
// host model driving serial data, shift clock, strobe and enable
`default_nettype none
module ssl_host_model (
  input  wire logic clk_sys,       // system clock
  output var  logic ser_data_pin,  // serial data
  output var  logic shift_clk_pin, // shift clock, idle low
  output var  logic strobe_pin,    // latch strobe
  output var  logic out_en_pin     // output enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // phase above the pin sync latency of the block
  localparam int PH = 5;
  initial begin
    ser_data_pin = 1'b0;
    shift_clk_pin = 1'b0;
    strobe_pin = 1'b0;
    out_en_pin = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data flips after the fall so stale bits never look valid
  task automatic send_bit(input logic b);
    @(negedge clk_sys);
    ser_data_pin = b;
    hold(PH);
    shift_clk_pin = 1'b1;
    hold(PH);
    shift_clk_pin = 1'b0;
    ser_data_pin = ~b;
    hold(PH);
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask
  task automatic set_strobe(input logic v);
    @(negedge clk_sys);
    strobe_pin = v;
    hold(PH);
  endtask
  task automatic set_oe(input logic v);
    @(negedge clk_sys);
    out_en_pin = v;
    hold(PH);
  endtask
endmodule
`default_nettype wire

/* tb/ssl_top_chk.sv */
// port checker for the shift latch top
`default_nettype none
module ssl_top_chk #(parameter int STAGES = 8) (
  input wire logic              clk_sys,           // clock
  input wire logic              rstn,              // reset, low
  input wire logic              ser_data_pin,      // data pin
  input wire logic              shift_clk_pin,     // shift pin
  input wire logic              strobe_pin,        // strobe pin
  input wire logic              out_en_pin,        // enable pin
  input wire logic [STAGES-1:0] parallel_out,      // latch out
  input wire logic [STAGES-1:0] parallel_out_oe_n, // enables
  input wire logic              cascade_rise_out,  // cascade
  input wire logic              cascade_fall_out,  // cascade
  input wire logic              cap_valid,         // fifo word
  input wire logic              cap_room,          // fifo room
  input wire logic              cap_overflow       // dropped
);
  // pin histories, bit k is the pin k+1 cycles ago
  logic [7:0] ck_h, sb_h, dt_h, oe_h, rs_h;
  always @(posedge clk_sys) begin
    ck_h <= {ck_h[6:0], shift_clk_pin};
    sb_h <= {sb_h[6:0], strobe_pin};
    dt_h <= {dt_h[6:0], ser_data_pin};
    oe_h <= {oe_h[6:0], out_en_pin};
    rs_h <= {rs_h[6:0], rstn};
  end
  // edges as seen after the three cycle pin path
  wire logic rise3 = ck_h[2] & !ck_h[3];
  wire logic fall3 = !ck_h[2] & ck_h[3];
  wire logic stb_hi = (sb_h[6:2] == 5'h1f);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  AST_RISE_ONLY: assert property (
    rs_h[4] && $changed(cascade_rise_out) |-> rise3)
    else $error("cascade_rise_out moved without a rise");
  AST_FALL_ONLY: assert property (
    rs_h[4] && $changed(cascade_fall_out) |-> fall3)
    else $error("cascade_fall_out moved without a fall");
  AST_FALL_COPY: assert property (
    rs_h[4] && fall3 |-> cascade_fall_out == $past(cascade_rise_out))
    else $error("cascade_fall_out did not copy");
  AST_STROBE_HOLD: assert property (
    rs_h[6] && sb_h[4:2] == 3'h0 |-> $stable(parallel_out))
    else $error("parallel_out changed with strobe low");
  AST_OE_TRACK: assert property (
    rs_h[3] |-> parallel_out_oe_n == {STAGES{!oe_h[2]}})
    else $error("output enables wrong");
  AST_LAST_IS_CASCADE: assert property (
    rs_h[4] && stb_hi |-> parallel_out[STAGES-1] == cascade_rise_out)
    else $error("last stage differs from cascade");
  AST_SHIFT_STEP: assert property (
    rs_h[5] && stb_hi && rise3 |->
    parallel_out == {$past(parallel_out[STAGES-2:0]), dt_h[2]})
    else $error("shift step wrong");
  AST_CAPTURE: assert property (
    $fell(strobe_pin) |-> ##[1:8] (cap_valid || cap_overflow))
    else $error("strobe fall captured nothing");
  cover property (rise3 && !out_en_pin);
  cover property (!cap_room);
  cover property (cap_overflow);
endmodule
`default_nettype wire

/* tb/ssl_top_tb_top.sv */
// bench top for the shift latch with its host model
`default_nettype none
module ssl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       cap_ready = 1'b0;
  logic       ovf_seen = 1'b0;
  int         failures, comparisons, pops;
  wire logic  ser_data_pin, shift_clk_pin, strobe_pin, out_en_pin;
  wire logic  cascade_rise_out, cascade_fall_out;
  wire logic  cap_valid, cap_room, cap_overflow;
  wire logic [7:0] parallel_out, parallel_out_oe_n, cap_data;
  wire logic [3:0] shift_count;
  always #5 clk_sys = ~clk_sys;
  ssl_top dut (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .ser_data_pin      (ser_data_pin),
    .shift_clk_pin     (shift_clk_pin),
    .strobe_pin        (strobe_pin),
    .out_en_pin        (out_en_pin),
    .parallel_out      (parallel_out),
    .parallel_out_oe_n (parallel_out_oe_n),
    .cascade_rise_out  (cascade_rise_out),
    .cascade_fall_out  (cascade_fall_out),
    .cap_data          (cap_data),
    .cap_valid         (cap_valid),
    .cap_ready         (cap_ready),
    .cap_room          (cap_room),
    .cap_overflow      (cap_overflow),
    .shift_count       (shift_count)
  );
  ssl_host_model host (
    .clk_sys       (clk_sys),
    .ser_data_pin  (ser_data_pin),
    .shift_clk_pin (shift_clk_pin),
    .strobe_pin    (strobe_pin),
    .out_en_pin    (out_en_pin)
  );
  // pops counted and drops flagged at the edge that takes them
  always @(posedge clk_sys) begin
    if (cap_valid === 1'b1 && cap_ready === 1'b1) pops <= pops + 1;
    if (cap_overflow === 1'b1) ovf_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_shift_latch();
    logic [7:0] seen;
    host.set_oe(1'b1);
    host.set_strobe(1'b1);
    host.send_byte(8'ha5);
    host.hold(6);
    chk(parallel_out, 8'ha5);
    chk({7'h0, cascade_rise_out}, 8'h01);
    chk({7'h0, cascade_fall_out}, 8'h01);
    host.set_strobe(1'b0);
    // alternate bits while the old byte leaves by the cascade
    for (int i = 0; i < 8; i++) begin
      seen = {seen[6:0], cascade_rise_out};
      host.send_bit(i[0]);
    end
    chk(seen, 8'ha5);
    chk({4'h0, shift_count}, 8'h08);
    chk(parallel_out, 8'ha5);
    chk(cap_data, 8'ha5);
    host.set_strobe(1'b1);
    chk(parallel_out, 8'h55);
    cap_ready = 1'b1;
    host.hold(1);
    cap_ready = 1'b0;
    host.hold(3);
    chk({7'h0, cap_valid}, 8'h00);
    $display("test shift_latch done");
  endtask
  task automatic t_oe();
    host.set_oe(1'b0);
    chk(parallel_out_oe_n, 8'hff);
    host.send_byte(8'h0f);
    host.hold(6);
    chk(parallel_out, 8'h0f);
    chk({4'h0, shift_count}, 8'h0f);
    host.set_oe(1'b1);
    chk(parallel_out_oe_n, 8'h00);
    $display("test oe done");
  endtask
  task automatic t_fifo();
    int p0;
    int n;
    // one drop past the 32 word depth
    for (int i = 0; i < 33; i++) begin
      host.set_strobe(1'b0);
      host.set_strobe(1'b1);
    end
    chk({6'h0, cap_room, ovf_seen}, 8'h01);
    chk(cap_data, 8'h0f);
    chk({4'h0, shift_count}, 8'h00);
    p0 = pops;
    cap_ready = 1'b1;
    n = 0;
    while (cap_valid === 1'b1 && n < 60) begin
      host.hold(1);
      n++;
    end
    cap_ready = 1'b0;
    host.hold(2);
    chk(8'(pops - p0), 8'h20);
    $display("test fifo done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    t_shift_latch();
    t_oe();
    t_fifo();
    tally_and_finish();
  end
  // watchdog well beyond the fewer than one thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
bind ssl_top ssl_top_chk #(.STAGES(STAGES)) u_chk (
  .clk_sys           (clk_sys),
  .rstn              (rstn),
  .ser_data_pin      (ser_data_pin),
  .shift_clk_pin     (shift_clk_pin),
  .strobe_pin        (strobe_pin),
  .out_en_pin        (out_en_pin),
  .parallel_out      (parallel_out),
  .parallel_out_oe_n (parallel_out_oe_n),
  .cascade_rise_out  (cascade_rise_out),
  .cascade_fall_out  (cascade_fall_out),
  .cap_valid         (cap_valid),
  .cap_room          (cap_room),
  .cap_overflow      (cap_overflow)
);
`default_nettype wire
